// File: hw/crp_pkg.sv
// Overview of operation
// - The parity record register is read-only, resets to zero and is updated with one computed parity bit per register on each write to index 1 to 7.
// - Parity record bit 7 covers the status register, bit 6 the configuration register, bit 5 the first control register and bit 4 the second control register.
// - Parity record bits 3 to 0 cover the first LED pattern upper and lower byte, then the second LED pattern upper and lower byte.
// - The first LED pattern is 16 bits, held as an upper and a lower byte, all cleared at reset.
// - The second LED pattern is 16 bits, held as an upper and a lower byte, all cleared at reset.
// - After start-up the transceiver channel defaults to 220 mA cut-off current, 100 us cut-off delay, 25 ms restart delay and 5 us debounce.
// - After start-up the supply-line switch defaults to 500 us cut-off delay and 64 ms restart delay.
// - At reset the output stage bits read 1,0,0 and the first control register holds enable 0, current 01, delay 00, restart 0, debounce 01.
// - At reset all status flags are 0 and the second control register holds pull-down 1, debounce 01 and other bits 0.
// - A register is left unchanged when the parity sent with its new data differs from the computed one.
// - A parity mismatch on a write to register index 1 to 7 sets the parity error flag and asserts the interrupt output toward the host.
// - Each LED driver steps through its 16-bit pattern one bit every 63 ms, lighting the LED for a one bit.
package crp_pkg;

    // ==========================================================
    // Register indices
    localparam logic [3:0] IDX_FAULT_FLAGS = 4'h0;
    localparam logic [3:0] IDX_STAGE_SEL = 4'h1;
    localparam logic [3:0] IDX_XCVR_CTRL = 4'h2;
    localparam logic [3:0] IDX_SUPPLY_CTRL = 4'h3;
    localparam logic [3:0] IDX_LED_ONE_HI = 4'h4;
    localparam logic [3:0] IDX_LED_ONE_LO = 4'h5;
    localparam logic [3:0] IDX_LED_TWO_HI = 4'h6;
    localparam logic [3:0] IDX_LED_TWO_LO = 4'h7;
    localparam logic [3:0] IDX_PARITY_REC = 4'h8;

    // ==========================================================
    // Parity record bit positions
    localparam int PB_STATUS = 7;
    localparam int PB_CONFIG = 6;
    localparam int PB_CTRL1 = 5;
    localparam int PB_CTRL2 = 4;
    localparam int PB_LED1_HI = 3;
    localparam int PB_LED1_LO = 2;
    localparam int PB_LED2_HI = 1;
    localparam int PB_LED2_LO = 0;

    // ==========================================================
    // Status bit positions
    localparam int SB_SUPPLY = 7;
    localparam int SB_OVT = 5;
    localparam int SB_XCVR_OL = 4;
    localparam int SB_AUX_OL = 3;
    localparam int SB_REG_UV = 1;
    localparam int SB_PARITY = 0;

    // ==========================================================
    // Reset values and writable masks
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_STAGE_SEL = 8'h80;
    localparam logic [7:0] RST_XCVR_CTRL = 8'h21;
    localparam logic [7:0] RST_SUPPLY_CTRL = 8'h21;
    localparam logic [7:0] MASK_STAGE_SEL = 8'he0;
    localparam logic [7:0] MASK_SUPPLY_CTRL = 8'hbf;

    // ==========================================================
    // Default parameter figures the reset codes stand for
    localparam int XCVR_CUTOFF_MA = 220;
    localparam int XCVR_CUTOFF_DELAY_US = 100;
    localparam int XCVR_RESTART_MS = 25;
    localparam int XCVR_DEBOUNCE_US = 5;
    localparam int SUPPLY_CUTOFF_DELAY_US = 500;
    localparam int SUPPLY_RESTART_MS = 64;

    // ==========================================================
    // Timing
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int LED_STEP_MS = 63;
    localparam int LED_STEP_CYCLES_DEF = LED_STEP_MS * CLK_FREQ_KHZ;
    localparam int LED_CNT_W = 23;
    localparam logic [3:0] LED_FIRST_BIT = 4'hf;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [2:0] parity;
        logic [3:0] index;
        logic [7:0] data;
    } crp_wr_s;

    typedef struct packed {
        logic valid;
        logic [3:0] index;
    } crp_rd_s;

    typedef struct packed {
        logic supply_line;
        logic overtemp;
        logic xcvr_overload;
        logic aux_overload;
        logic regulator_uv;
    } crp_fault_s;

    typedef struct packed {
        logic [7:0] stage_sel;
        logic [7:0] xcvr_ctrl;
        logic [7:0] supply_ctrl;
    } crp_cfg_s;

endpackage : crp_pkg

// File: hw/crp_regs.sv
`timescale 1ns/1ps
`default_nettype none
module crp_regs #(
    parameter int LED_STEP_CYCLES = crp_pkg::LED_STEP_CYCLES_DEF
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Register traffic from the frame handler
    input wire crp_pkg::crp_wr_s wr_i,
    input wire crp_pkg::crp_rd_s rd_i,
    output logic [7:0] rd_data_o,
    // Fault detectors
    input wire crp_pkg::crp_fault_s fault_i,
    // Settings toward the output stage
    output crp_pkg::crp_cfg_s cfg_o,
    // Open-drain pins: low level driven while enable is high
    output logic irq_dat_o,
    output logic irq_oe_o,
    output logic led_dat_o,
    output logic led_one_oe_o,
    output logic led_two_oe_o
);
    import crp_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic byte_parity(input logic [7:0] b);
        byte_parity = ^b;
    endfunction : byte_parity

    function automatic logic [2:0] frame_parity(input logic [7:0] b);
        frame_parity = {b[6] ^ b[4] ^ b[2] ^ b[0],
                        b[7] ^ b[5] ^ b[3] ^ b[1],
                        ^b};
    endfunction : frame_parity

    // ==========================================================
    // Register bank
    logic [7:0] status_q, status_d;
    logic [7:0] stage_q, stage_d;
    logic [7:0] ctrl1_q, ctrl1_d;
    logic [7:0] ctrl2_q, ctrl2_d;
    logic [15:0] led_one_q, led_one_d;
    logic [15:0] led_two_q, led_two_d;
    logic [7:0] parity_q, parity_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic irq_oe_q, irq_oe_d;
    logic wr_ok;
    logic wr_known;

    always_comb
    begin
        status_d = status_q;
        stage_d = stage_q;
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        led_one_d = led_one_q;
        led_two_d = led_two_q;
        parity_d = parity_q;
        rd_data_d = rd_data_q;
        wr_known = (wr_i.index >= IDX_STAGE_SEL)
                && (wr_i.index <= IDX_LED_TWO_LO);
        wr_ok = (frame_parity(wr_i.data) == wr_i.parity);

        // Reading status acknowledges the sticky flags
        if (rd_i.valid && rd_i.index == IDX_FAULT_FLAGS)
        begin
            status_d = RST_ZERO;
        end

        // Set after clear so a fresh event is never lost
        status_d[SB_SUPPLY] = status_d[SB_SUPPLY] | fault_i.supply_line;
        status_d[SB_OVT] = status_d[SB_OVT] | fault_i.overtemp;
        status_d[SB_XCVR_OL] = status_d[SB_XCVR_OL] | fault_i.xcvr_overload;
        status_d[SB_AUX_OL] = status_d[SB_AUX_OL] | fault_i.aux_overload;
        status_d[SB_REG_UV] = status_d[SB_REG_UV] | fault_i.regulator_uv;

        if (wr_i.valid && wr_known)
        begin
            parity_d[PB_STATUS] = byte_parity(status_q);
            unique case (wr_i.index)
                IDX_STAGE_SEL:
                begin
                    parity_d[PB_CONFIG] = byte_parity(wr_i.data);
                    if (wr_ok)
                    begin
                        stage_d = wr_i.data & MASK_STAGE_SEL;
                    end
                end
                IDX_XCVR_CTRL:
                begin
                    parity_d[PB_CTRL1] = byte_parity(wr_i.data);
                    if (wr_ok)
                    begin
                        ctrl1_d = wr_i.data;
                    end
                end
                IDX_SUPPLY_CTRL:
                begin
                    parity_d[PB_CTRL2] = byte_parity(wr_i.data);
                    if (wr_ok)
                    begin
                        ctrl2_d = wr_i.data & MASK_SUPPLY_CTRL;
                    end
                end
                IDX_LED_ONE_HI:
                begin
                    parity_d[PB_LED1_HI] = byte_parity(wr_i.data);
                    if (wr_ok)
                    begin
                        led_one_d[15:8] = wr_i.data;
                    end
                end
                IDX_LED_ONE_LO:
                begin
                    parity_d[PB_LED1_LO] = byte_parity(wr_i.data);
                    if (wr_ok)
                    begin
                        led_one_d[7:0] = wr_i.data;
                    end
                end
                IDX_LED_TWO_HI:
                begin
                    parity_d[PB_LED2_HI] = byte_parity(wr_i.data);
                    if (wr_ok)
                    begin
                        led_two_d[15:8] = wr_i.data;
                    end
                end
                IDX_LED_TWO_LO:
                begin
                    parity_d[PB_LED2_LO] = byte_parity(wr_i.data);
                    if (wr_ok)
                    begin
                        led_two_d[7:0] = wr_i.data;
                    end
                end
                default:
                begin
                    parity_d = parity_q;
                end
            endcase
            if (!wr_ok)
            begin
                status_d[SB_PARITY] = 1'b1;
            end
        end

        // Interrupt follows any standing flag, parity error included
        irq_oe_d = |status_d;

        if (rd_i.valid)
        begin
            unique case (rd_i.index)
                IDX_FAULT_FLAGS: rd_data_d = status_q;
                IDX_STAGE_SEL: rd_data_d = stage_q;
                IDX_XCVR_CTRL: rd_data_d = ctrl1_q;
                IDX_SUPPLY_CTRL: rd_data_d = ctrl2_q;
                IDX_LED_ONE_HI: rd_data_d = led_one_q[15:8];
                IDX_LED_ONE_LO: rd_data_d = led_one_q[7:0];
                IDX_LED_TWO_HI: rd_data_d = led_two_q[15:8];
                IDX_LED_TWO_LO: rd_data_d = led_two_q[7:0];
                IDX_PARITY_REC: rd_data_d = parity_q;
                default: rd_data_d = RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            status_q <= RST_ZERO;
            stage_q <= RST_STAGE_SEL;
            ctrl1_q <= RST_XCVR_CTRL;
            ctrl2_q <= RST_SUPPLY_CTRL;
            led_one_q <= {RST_ZERO, RST_ZERO};
            led_two_q <= {RST_ZERO, RST_ZERO};
            parity_q <= RST_ZERO;
            rd_data_q <= RST_ZERO;
            irq_oe_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            stage_q <= stage_d;
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            led_one_q <= led_one_d;
            led_two_q <= led_two_d;
            parity_q <= parity_d;
            rd_data_q <= rd_data_d;
            irq_oe_q <= irq_oe_d;
        end
    end

    // ==========================================================
    // LED sequencer, both drivers share one bit clock
    localparam logic [LED_CNT_W-1:0] STEP_LAST =
        LED_CNT_W'(LED_STEP_CYCLES - 1);
    logic [LED_CNT_W-1:0] step_q, step_d;
    logic [3:0] bit_q, bit_d;
    logic led_one_on_q, led_one_on_d;
    logic led_two_on_q, led_two_on_d;

    always_comb
    begin
        step_d = step_q + LED_CNT_W'(1);
        bit_d = bit_q;
        if (step_q >= STEP_LAST)
        begin
            step_d = '0;
            bit_d = bit_q - 4'h1;
        end
        led_one_on_d = led_one_q[bit_q];
        led_two_on_d = led_two_q[bit_q];
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            step_q <= '0;
            bit_q <= LED_FIRST_BIT;
            led_one_on_q <= 1'b0;
            led_two_on_q <= 1'b0;
        end
        else
        begin
            step_q <= step_d;
            bit_q <= bit_d;
            led_one_on_q <= led_one_on_d;
            led_two_on_q <= led_two_on_d;
        end
    end

    // ==========================================================
    // Outputs
    logic low_q;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            low_q <= 1'b0;
        end
        else
        begin
            low_q <= 1'b0;
        end
    end

    assign rd_data_o = rd_data_q;
    assign cfg_o = '{stage_sel: stage_q, xcvr_ctrl: ctrl1_q,
                     supply_ctrl: ctrl2_q};
    assign irq_dat_o = low_q;
    assign irq_oe_o = irq_oe_q;
    assign led_dat_o = low_q;
    assign led_one_oe_o = led_one_on_q;
    assign led_two_oe_o = led_two_on_q;

endmodule : crp_regs
`default_nettype wire

// File: bench/crp_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module crp_regs_checker
    import crp_pkg::*;
#(
    parameter int LED_STEP_CYCLES = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Register traffic
    input wire crp_pkg::crp_wr_s wr_i,
    input wire crp_pkg::crp_rd_s rd_i,
    input wire logic [7:0] rd_data_o,
    input wire crp_pkg::crp_fault_s fault_i,
    // Outputs
    input wire crp_pkg::crp_cfg_s cfg_o,
    input wire logic irq_dat_o,
    input wire logic irq_oe_o,
    input wire logic led_dat_o,
    input wire logic led_one_oe_o,
    input wire logic led_two_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] d;
    logic [2:0] par_w;
    logic bad_w;
    assign d = wr_i.data;
    assign par_w = {d[6]^d[4]^d[2]^d[0], d[7]^d[5]^d[3]^d[1], ^d};
    assign bad_w = wr_i.valid && wr_i.index inside {[4'h1:4'h7]}
        && wr_i.parity != par_w;
    sequence wr_then_rec;
        wr_i.valid && wr_i.index == 4'h4 ##2 rd_i.valid && rd_i.index == 4'h8;
    endsequence
    // ==========================================================
    // Properties
    bad_irq_a: assert property (bad_w |=> irq_oe_o)
        else $error("irq not raised after bad parity");
    flt_irq_a: assert property (|fault_i |=> irq_oe_o)
        else $error("irq not raised after fault");
    bad_keep_a: assert property (bad_w && wr_i.index == 4'h2
        |=> $stable(cfg_o.xcvr_ctrl)) else $error("bad write changed reg");
    good_wr_a: assert property (wr_i.valid && !bad_w && wr_i.index == 4'h2
        |=> cfg_o.xcvr_ctrl == $past(wr_i.data)) else $error("write lost");
    rst_cfg_a: assert property ($fell(sys_rst_i) |-> cfg_o == 24'h802121)
        else $error("config reset value wrong");
    rst_idle_a: assert property ($fell(sys_rst_i)
        |-> !irq_oe_o && rd_data_o == 8'h00) else $error("reset state wrong");
    led_dark_a: assert property ($fell(sys_rst_i)
        |-> (!led_one_oe_o && !led_two_oe_o)[*8]) else $error("led lit");
    unused_zero_a: assert property (cfg_o.stage_sel[4:0] == 5'h00
        && !cfg_o.supply_ctrl[6] && !irq_dat_o && !led_dat_o)
        else $error("unused bit set");
    rec_par_a: assert property (wr_then_rec
        |=> rd_data_o[3] == ^$past(wr_i.data, 3)) else $error("record bad");
endmodule : crp_regs_checker
`default_nettype wire

// File: bench/crp_host.sv
`timescale 1ns/1ps
`default_nettype none
module crp_host
    import crp_pkg::*;
(
    // Clock and read data
    input wire logic ref_clk_i,
    input wire logic [7:0] rd_data_i,
    // Requests
    output var crp_pkg::crp_wr_s wr_o,
    output var crp_pkg::crp_rd_s rd_o
);
    initial
    begin
        wr_o <= '0;
        rd_o <= '0;
    end
    // Idle fields are inverted so a stale value is never mistaken
    // Each call opens on a fresh edge, so a request is never raised in
    // the time step in which the previous one was released
    task automatic put(input logic [3:0] idx, input logic [7:0] d,
                       input logic bad);
        logic [2:0] p;
        p = {d[6]^d[4]^d[2]^d[0], d[7]^d[5]^d[3]^d[1], ^d};
        @(posedge ref_clk_i);
        wr_o <= {1'b1, p ^ {2'b00, bad}, idx, d};
        @(posedge ref_clk_i);
        wr_o <= {1'b0, ~wr_o[14:0]};
    endtask : put
    task automatic get(input logic [3:0] idx, output logic [7:0] d);
        @(posedge ref_clk_i);
        rd_o <= {1'b1, idx};
        @(posedge ref_clk_i);
        rd_o <= {1'b0, ~rd_o.index};
        // Read data is registered: take it one edge later, where it stands
        @(posedge ref_clk_i);
        d = rd_data_i;
    endtask : get
    // Status first, then record, to find the write to repeat
    task automatic service(output logic [7:0] st, output logic [7:0] rec);
        get(IDX_FAULT_FLAGS, st);
        get(IDX_PARITY_REC, rec);
    endtask : service
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : idle
endmodule : crp_host
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import crp_pkg::*;
    localparam int STEP = 4;
    localparam logic [7:0] DAT [1:7] = '{8'hff, 8'h5b, 8'hff, 8'h81,
                                         8'h7f, 8'h00, 8'hc1};
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    crp_wr_s wr_i;
    crp_rd_s rd_i;
    crp_fault_s fault_i = '0;
    crp_cfg_s cfg_o;
    logic [7:0] rd_data_o;
    logic irq_dat_o, irq_oe_o, led_dat_o, led_one_oe_o, led_two_oe_o;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    crp_regs #(.LED_STEP_CYCLES(STEP)) crp_regs_inst (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .wr_i(wr_i),
        .rd_i(rd_i), .rd_data_o(rd_data_o), .fault_i(fault_i),
        .cfg_o(cfg_o), .irq_dat_o(irq_dat_o), .irq_oe_o(irq_oe_o),
        .led_dat_o(led_dat_o), .led_one_oe_o(led_one_oe_o),
        .led_two_oe_o(led_two_oe_o));
    crp_host crp_host_inst (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data_o),
        .wr_o(wr_i), .rd_o(rd_i));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        crp_host_inst.get(idx, v);
        check({16'h0000, v}, {16'h0000, exp});
    endtask : rd_chk
    task automatic give_verdict();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // Generous ceiling: the whole sequence needs a few hundred cycles
    always @(posedge ref_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    // ==========================================================
    // Tests
    initial
    begin
        logic [7:0] st, rec, exp_rec;
        int hi1, hi2;
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        crp_host_inst.idle(1);
        check(cfg_o, 24'h802121);
        rd_chk(IDX_FAULT_FLAGS, 8'h00);
        rd_chk(IDX_STAGE_SEL, 8'h80);
        rd_chk(IDX_XCVR_CTRL, 8'h21);
        rd_chk(IDX_SUPPLY_CTRL, 8'h21);
        for (int i = 4; i < 9; i++)
            rd_chk(4'(i), 8'h00);
        $display("test reset values done");
        exp_rec = 8'h00;
        for (int i = 1; i < 8; i++)
        begin
            crp_host_inst.put(4'(i), DAT[i], 1'b0);
            exp_rec[7 - i] = ^DAT[i];
        end
        crp_host_inst.put(IDX_LED_ONE_HI, DAT[4], 1'b0);
        rd_chk(IDX_PARITY_REC, exp_rec);
        check(cfg_o, {8'he0, DAT[2], 8'hbf});
        for (int i = 4; i < 8; i++)
            rd_chk(4'(i), DAT[i]);
        $display("test good writes done");
        crp_host_inst.put(IDX_XCVR_CTRL, 8'h56, 1'b1);
        exp_rec[PB_CTRL1] = ^8'h56;
        crp_host_inst.idle(1);
        check({23'h0, irq_oe_o}, 24'h1);
        crp_host_inst.put(IDX_PARITY_REC, 8'hff, 1'b0);
        crp_host_inst.put(IDX_FAULT_FLAGS, 8'hff, 1'b0);
        rd_chk(IDX_XCVR_CTRL, DAT[2]);
        rd_chk(4'h9, 8'h00);
        crp_host_inst.service(st, rec);
        check({st, rec}, {8'h01, exp_rec});
        check({23'h0, irq_oe_o}, 24'h0);
        $display("test parity error done");
        fault_i <= 5'h1f;
        crp_host_inst.idle(1);
        fault_i <= 5'h00;
        crp_host_inst.put(IDX_LED_TWO_LO, 8'hc1, 1'b0);
        exp_rec[PB_STATUS] = ^8'hba;
        crp_host_inst.service(st, rec);
        check({st, rec}, {8'hba, exp_rec});
        $display("test fault flags done");
        crp_host_inst.put(IDX_LED_ONE_HI, 8'h80, 1'b0);
        crp_host_inst.put(IDX_LED_ONE_LO, 8'h01, 1'b0);
        crp_host_inst.put(IDX_LED_TWO_HI, 8'h00, 1'b0);
        crp_host_inst.put(IDX_LED_TWO_LO, 8'hff, 1'b0);
        crp_host_inst.idle(2);
        hi1 = 0;
        hi2 = 0;
        // Two full pattern periods, so the count does not depend on phase
        repeat (32 * STEP)
        begin
            @(posedge ref_clk_i);
            hi1 += int'(led_one_oe_o);
            hi2 += int'(led_two_oe_o);
        end
        check(24'(hi1), 24'(4 * STEP));
        check(24'(hi2), 24'(16 * STEP));
        $display("test led sequence done");
        give_verdict();
    end
endmodule : tb
bind crp_regs crp_regs_checker #(.LED_STEP_CYCLES(LED_STEP_CYCLES))
    crp_regs_checker_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .fault_i(fault_i),
    .cfg_o(cfg_o), .irq_dat_o(irq_dat_o), .irq_oe_o(irq_oe_o),
    .led_dat_o(led_dat_o), .led_one_oe_o(led_one_oe_o),
    .led_two_oe_o(led_two_oe_o));
`default_nettype wire
